// ### core/rsm_regs.svh
// Register offsets, field positions and reset values of the receiver monitor bank
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH
`define RSM_ADDR_OUTCOME 8'h37
`define RSM_ADDR_FAULT 8'h38
`define RSM_ADDR_STRENGTH 8'h39
`define RSM_ADDR_SETUP 8'h3a
`define RSM_ADDR_PAT0 8'h3b
`define RSM_ADDR_PAT1 8'h3c
`define RSM_ADDR_PAT2 8'h3d
`define RSM_ADDR_PAT3 8'h3e
`define RSM_OUTCOME_BIT 7
`define RSM_TOL_HI 6
`define RSM_TOL_LO 5
`define RSM_LEN_HI 4
`define RSM_LEN_LO 0
`define RSM_LEN_ZERO_CHIPS 6'h20
`define RSM_RST_BYTE 8'h00
`define RSM_SETUP_MASK 8'h7f
`endif

// ### core/rsm_pkg.sv
// Types shared by the receiver monitor bank
package rsm_pkg;
  // Receive sub-command active when status was sampled
  typedef enum logic [1:0] {
    RSM_CMD_IDLE = 2'b00,
    RSM_CMD_WAKEUP_SEARCH = 2'b01,
    RSM_CMD_PREAMBLE_HUNT = 2'b10,
    RSM_CMD_DATA_RECEIVE = 2'b11
  } rsm_cmd_t;
  // Receive activity state seen by the stop logic
  typedef enum logic [1:0] {
    RSM_ACT_OFF = 2'b00,
    RSM_ACT_RUN = 2'b01,
    RSM_ACT_HALT = 2'b10,
    RSM_ACT_DOWN = 2'b11
  } rsm_act_t;
endpackage : rsm_pkg

// ### core/rsm_snapshot.sv
// Consistent capture of monitor outcome, faults, strength and sub-command
`timescale 1ns/100ps
`include "rsm_regs.svh"
module rsm_snapshot (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic done, // Search or preamble hunt completed
  input wire logic sample, // Host triggered status sampling
  input wire logic failed,
  input wire logic [7:0] fault_in,
  input wire logic [7:0] strength_in,
  input wire rsm_pkg::rsm_cmd_t cmd_in,
  output logic [7:0] outcome,
  output logic [7:0] fault,
  output logic [7:0] strength,
  output rsm_pkg::rsm_cmd_t cmd
);
  logic [7:0] next_outcome;
  logic [7:0] next_fault;
  logic [7:0] next_strength;
  rsm_pkg::rsm_cmd_t next_cmd;

  // Next values; outcome and faults change only together on completion
  always_comb begin
    next_outcome = outcome;
    next_fault = fault;
    next_strength = strength;
    next_cmd = cmd;
    if (done) begin // [R14]
      // Outcome 1 means a decision exists; bit 7 carries fail [R1] [R4]
      next_outcome = {failed, 7'h7f}; // [R2]
      next_fault = fault_in; // [R3]
      next_strength = strength_in; // [R6]
      next_cmd = cmd_in; // [R13]
    end else if (sample) begin
      next_strength = strength_in; // [R7]
      next_cmd = cmd_in; // [R13]
    end
  end

  // Registers; reset gives the no-decision pattern 0/0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outcome <= `RSM_RST_BYTE;
      fault <= `RSM_RST_BYTE;
      strength <= `RSM_RST_BYTE;
      cmd <= rsm_pkg::RSM_CMD_IDLE;
    end else begin
      outcome <= next_outcome;
      fault <= next_fault;
      strength <= next_strength;
      cmd <= next_cmd;
    end
  end

  // Never the impossible 0/1 code on bits 6..0 [R4]
  no_impossible_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((~outcome[6:0]) & fault[6:0]) == 7'h00) else $error("status 0 with error 1");
  // Completion updates faults and strength together [R14]
  joint_update_a: assert property (@(posedge clk) disable iff (!rst_b)
    done |=> (fault == $past(fault_in)) && (strength == $past(strength_in)))
    else $error("snapshot not joint");
  // Outcome bit follows the fail input [R1]
  outcome_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    done |=> outcome[7] == $past(failed)) else $error("outcome flag wrong");
  // Host sample alone leaves faults untouched [R7]
  sample_strength_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sample && !done) |=> strength == $past(strength_in) && $stable(fault))
    else $error("sample capture wrong");
endmodule : rsm_snapshot

// ### core/rsm_monitor_regs.sv
// Receiver monitor status, strength and preamble setup register bank
`timescale 1ns/100ps
`include "rsm_regs.svh"
// Overview of operation
// (R1) Bit 7 set on failed search
// (R2) Bits 6..0 report seven diagnostic categories
// (R3) Fault register: bit 7 wakeup timeout, rest categories
// (R4) Status/error pair encodes decision state per bit
// (R5) Host may read other status for detail
// (R6) Capture strength on search completion
// (R7) Capture strength on host sampling trigger
// (R8) Bits 6:5 give allowed chip errors
// (R9) Bits 4:0 give length, zero means 32
// (R10) Pattern stored over four consecutive bytes
// (R11) First-sent chip is pattern MSB
// (R12) Stop: power down if option set
// (R13) Record active sub-command as two bits
// (R14) Update flags and strength together
module rsm_monitor_regs (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR, // Register address from the serial interface
  input wire logic REG_WR, // One-cycle write strobe
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD, // One-cycle read strobe
  output logic [7:0] REG_RDATA, // Read data, registered
  input wire logic SEARCH_DONE, // Search or preamble hunt finished, pulse
  input wire logic SEARCH_FAILED,
  input wire logic [7:0] FAULT_IN, // Wakeup timeout plus seven categories
  input wire logic [7:0] STRENGTH_IN, // Live strength conversion result
  input wire logic SAMPLE_TRIG, // Host triggered status sample, pulse
  input wire rsm_pkg::rsm_cmd_t CMD_IN,
  input wire logic RX_START,
  input wire logic RX_STOP, // Stop request, pulse
  input wire logic STOP_POWER_DOWN, // Stop option bit
  input wire logic CHIP_IN, // Received chip
  input wire logic CHIP_VALID, // Chip strobe
  output logic PREAMBLE_FOUND, // Preamble matched, registered; high while the match holds
  output logic [1:0] CHIP_TOLERANCE,
  output logic [5:0] CHIP_LENGTH, // 1 to 32
  output rsm_pkg::rsm_cmd_t CMD_SAMPLED,
  output logic RX_ACTIVE,
  output logic POWER_DOWN
);
  logic [7:0] preamble_detect_setup; // Tolerance and length
  logic [31:0] pattern; // Reference chips, byte0 at bits 7:0
  logic [31:0] shift; // Received chips, newest in bit 0
  rsm_pkg::rsm_act_t act;
  logic [7:0] rdata;
  logic [7:0] next_setup;
  logic [31:0] next_pattern;
  logic [31:0] next_shift;
  rsm_pkg::rsm_act_t next_act;
  logic [7:0] next_rdata;
  logic found;
  logic [7:0] outcome;
  logic [7:0] fault;
  logic [7:0] strength;
  logic [5:0] len;
  logic [31:0] len_mask;
  logic [5:0] errs;

  // Count of set bits, used for chip error counting
  function automatic logic [5:0] pop32(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction : pop32

  // Setup field decode; zero length means full 32 chips
  function automatic logic [5:0] chip_len(input logic [7:0] s);
    logic [4:0] f;
    f = s[`RSM_LEN_HI:`RSM_LEN_LO];
    return (f == 5'h00) ? `RSM_LEN_ZERO_CHIPS : {1'b0, f}; // [R9]
  endfunction : chip_len

  // Snapshot of outcome, faults and strength
  rsm_snapshot u_snap (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .done(SEARCH_DONE),
    .sample(SAMPLE_TRIG),
    .failed(SEARCH_FAILED),
    .fault_in(FAULT_IN),
    .strength_in(STRENGTH_IN),
    .cmd_in(CMD_IN),
    .outcome(outcome),
    .fault(fault),
    .strength(strength),
    .cmd(CMD_SAMPLED)
  );

  assign len = chip_len(preamble_detect_setup);
  assign CHIP_LENGTH = len;
  assign CHIP_TOLERANCE = preamble_detect_setup[`RSM_TOL_HI:`RSM_TOL_LO]; // [R8]
  // Only the newest len chips take part in the comparison
  assign len_mask = (len == `RSM_LEN_ZERO_CHIPS) ? 32'hffffffff
                  : ((32'h00000001 << len[4:0]) - 32'h00000001);
  // Oldest chip lands highest, so MSB-first matches pattern directly [R11]
  assign errs = pop32((shift ^ pattern) & len_mask);
  assign found = (act == rsm_pkg::RSM_ACT_RUN) && (errs <= {4'h0, CHIP_TOLERANCE}); // [R8]
  assign REG_RDATA = rdata;
  assign RX_ACTIVE = (act == rsm_pkg::RSM_ACT_RUN);
  assign POWER_DOWN = (act == rsm_pkg::RSM_ACT_DOWN);

  // Next values of setup, pattern, chip history, activity and read data
  always_comb begin
    next_setup = preamble_detect_setup;
    next_pattern = pattern;
    next_shift = shift;
    next_act = act;
    next_rdata = rdata;
    if (REG_WR) begin
      case (REG_ADDR)
        `RSM_ADDR_SETUP: next_setup = REG_WDATA & `RSM_SETUP_MASK;
        `RSM_ADDR_PAT0: next_pattern[7:0] = REG_WDATA; // [R10]
        `RSM_ADDR_PAT1: next_pattern[15:8] = REG_WDATA; // [R10]
        `RSM_ADDR_PAT2: next_pattern[23:16] = REG_WDATA; // [R10]
        `RSM_ADDR_PAT3: next_pattern[31:24] = REG_WDATA; // [R10]
        default: next_pattern = pattern; // Read-only or unmapped: ignored
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        `RSM_ADDR_OUTCOME: next_rdata = outcome; // [R1] [R2]
        `RSM_ADDR_FAULT: next_rdata = fault; // [R3]
        `RSM_ADDR_STRENGTH: next_rdata = strength; // [R6]
        `RSM_ADDR_SETUP: next_rdata = preamble_detect_setup;
        `RSM_ADDR_PAT0: next_rdata = pattern[7:0];
        `RSM_ADDR_PAT1: next_rdata = pattern[15:8];
        `RSM_ADDR_PAT2: next_rdata = pattern[23:16];
        `RSM_ADDR_PAT3: next_rdata = pattern[31:24];
        default: next_rdata = `RSM_RST_BYTE; // Unmapped reads zero
      endcase
    end
    // History restarts on each start so stale chips never match
    if (RX_START) begin
      next_shift = 32'h00000000;
    end else if (CHIP_VALID && act == rsm_pkg::RSM_ACT_RUN) begin
      next_shift = {shift[30:0], CHIP_IN};
    end
    // Stop wins over start; power-down chosen by the option bit
    case (act)
      rsm_pkg::RSM_ACT_RUN: begin
        if (RX_STOP) begin
          next_act = STOP_POWER_DOWN ? rsm_pkg::RSM_ACT_DOWN
                                     : rsm_pkg::RSM_ACT_HALT; // [R12]
        end
      end
      rsm_pkg::RSM_ACT_OFF, rsm_pkg::RSM_ACT_HALT, rsm_pkg::RSM_ACT_DOWN: begin
        if (RX_START && !RX_STOP) begin
          next_act = rsm_pkg::RSM_ACT_RUN;
        end
      end
      default: next_act = rsm_pkg::RSM_ACT_OFF;
    endcase
  end

  // State registers
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      preamble_detect_setup <= `RSM_RST_BYTE;
      pattern <= 32'h00000000;
      shift <= 32'h00000000;
      act <= rsm_pkg::RSM_ACT_OFF;
      rdata <= `RSM_RST_BYTE;
      PREAMBLE_FOUND <= 1'b0;
    end else begin
      preamble_detect_setup <= next_setup;
      pattern <= next_pattern;
      shift <= next_shift;
      act <= next_act;
      rdata <= next_rdata;
      PREAMBLE_FOUND <= found;
    end
  end

  // Stop chooses power-down or halt within one cycle [R12]
  stop_choice_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (RX_ACTIVE && RX_STOP) |=> (POWER_DOWN == $past(STOP_POWER_DOWN)) && !RX_ACTIVE)
    else $error("stop option ignored");
  // A written length of zero decodes to the full 32 chips [R9]
  length_zero_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (REG_WR && REG_ADDR == `RSM_ADDR_SETUP && REG_WDATA[`RSM_LEN_HI:`RSM_LEN_LO] == 5'h00)
    |=> CHIP_LENGTH == `RSM_LEN_ZERO_CHIPS)
    else $error("length zero not 32");
  // A byte0 write lands in the low chips of the pattern [R10]
  pattern_rw_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (REG_WR && REG_ADDR == `RSM_ADDR_PAT0) |=> pattern[7:0] == $past(REG_WDATA))
    else $error("pattern byte lost");
  // A setup write reaches the detector tolerance one cycle later [R8]
  tolerance_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (REG_WR && REG_ADDR == `RSM_ADDR_SETUP)
    |=> CHIP_TOLERANCE == $past(REG_WDATA[`RSM_TOL_HI:`RSM_TOL_LO]))
    else $error("tolerance wrong");
endmodule : rsm_monitor_regs

// ### dv/rsm_host_model.sv
// Host microcontroller model that drives the register strobes
`timescale 1ns/100ps
module rsm_host_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd,
  input wire logic [7:0] rdata
);
  // Idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write; strobe drops one edge later, so back-to-back calls never clash
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : put
  // Read; data is registered, so it is taken one edge after the strobe
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask : get
endmodule : rsm_host_model

// ### dv/testbench.sv
// Self-checking bench of the receiver monitor register bank
`timescale 1ns/100ps
module testbench;
  logic clk, rst_b, wr, rd, done, fail, smp, start, stop, spd, chip, cv, seen, seen_clr;
  logic [7:0] addr, wdata, rdata, flt, str, got;
  logic found, act, pd;
  logic [1:0] tol;
  logic [5:0] len;
  rsm_pkg::rsm_cmd_t cmd, cmd_s;
  int bad_count, tests_run;
  // Host drives the register side
  rsm_host_model host (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata));
  rsm_monitor_regs DUT (.REF_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .SEARCH_DONE(done),
    .SEARCH_FAILED(fail), .FAULT_IN(flt), .STRENGTH_IN(str), .SAMPLE_TRIG(smp),
    .CMD_IN(cmd), .RX_START(start), .RX_STOP(stop), .STOP_POWER_DOWN(spd), .CHIP_IN(chip),
    .CHIP_VALID(cv), .PREAMBLE_FOUND(found), .CHIP_TOLERANCE(tol), .CHIP_LENGTH(len),
    .CMD_SAMPLED(cmd_s), .RX_ACTIVE(act), .POWER_DOWN(pd));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sticky note of any match pulse; one process owns it, the sequence only asks for a clear
  always @(posedge clk) begin
    if (seen_clr) begin
      seen <= 1'b0;
    end else if (found === 1'b1) begin
      seen <= 1'b1;
    end
  end
  // Compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Register read with compare
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.get(a, got);
    chk(got, e);
  endtask : rdc
  // One-cycle event: completion when s is 0, host sample when s is 1
  task automatic ev(input logic s, input logic f, input logic [7:0] x, input logic [7:0] y,
                    input rsm_pkg::rsm_cmd_t c);
    @(posedge clk);
    done <= ~s;
    smp <= s;
    fail <= f;
    flt <= x;
    str <= y;
    cmd <= c;
    @(posedge clk);
    done <= 1'b0;
    smp <= 1'b0;
    str <= ~y; // Live value moves on; the capture must not follow it
  endtask : ev
  // Verdict and end of run
  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // Watchdog well beyond the fewer than two hundred cycles needed
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  // Main sequence
  initial begin
    {rst_b, done, fail, smp, start, stop, spd, chip, cv, seen_clr} = '0;
    {flt, str} = '0;
    cmd = rsm_pkg::RSM_CMD_IDLE;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdc(8'h37, 8'h00);
    rdc(8'h38, 8'h00);
    chk({2'h0, len}, 8'h20);
    host.put(8'h3a, 8'hff);
    rdc(8'h3a, 8'h7f);
    chk({6'h00, tol}, 8'h03);
    chk({2'h0, len}, 8'h1f);
    host.put(8'h3a, 8'h25);
    // The write lands on this edge; look once the register has settled
    #1 chk({6'h00, tol}, 8'h01);
    chk({2'h0, len}, 8'h05);
    host.put(8'h3a, 8'h60);
    #1 chk({2'h0, len}, 8'h20);
    chk({6'h00, tol}, 8'h03);
    for (int i = 0; i < 4; i++) host.put(8'h3b + 8'(i), 8'h5a ^ 8'(i));
    for (int i = 0; i < 4; i++) rdc(8'h3b + 8'(i), 8'h5a ^ 8'(i));
    host.put(8'h39, 8'hee);
    rdc(8'h39, 8'h00);
    rdc(8'h40, 8'h00);
    // Failed search, then a clean one
    ev(1'b0, 1'b1, 8'h85, 8'ha5, rsm_pkg::RSM_CMD_WAKEUP_SEARCH);
    rdc(8'h37, 8'hff);
    rdc(8'h38, 8'h85);
    rdc(8'h39, 8'ha5);
    chk({6'h00, cmd_s}, 8'h01);
    ev(1'b0, 1'b0, 8'h00, 8'h5a, rsm_pkg::RSM_CMD_PREAMBLE_HUNT);
    rdc(8'h37, 8'h7f);
    rdc(8'h38, 8'h00);
    // Host samples leave the outcome alone
    for (int i = 0; i < 4; i++) begin
      ev(1'b1, 1'b1, 8'hff, 8'h30 + 8'(i), rsm_pkg::rsm_cmd_t'(2'(i)));
      rdc(8'h39, 8'h30 + 8'(i));
      chk({6'h00, cmd_s}, 8'(i));
    end
    rdc(8'h37, 8'h7f);
    // Preamble 8'hb4 over 8 chips, MSB first; one flipped chip against tolerance
    host.put(8'h3b, 8'hb4);
    for (int k = 0; k < 3; k++) begin
      host.put(8'h3a, (k == 2) ? 8'h28 : 8'h08);
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      seen_clr <= 1'b1;
      #1 chk({7'h00, act}, 8'h01);
      for (int b = 7; b >= 0; b--) begin
        @(posedge clk);
        chip <= 1'((8'hb4 ^ ((k == 0) ? 8'h00 : 8'h10)) >> b);
        cv <= 1'b1;
        seen_clr <= 1'b0;
        @(posedge clk);
        cv <= 1'b0;
      end
      repeat (4) @(posedge clk);
      #1 chk({7'h00, seen}, (k == 1) ? 8'h00 : 8'h01);
      @(posedge clk);
      spd <= (k == 2);
      stop <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
      #1 chk({6'h00, act, pd}, (k == 2) ? 8'h01 : 8'h00);
    end
    conclude();
  end
endmodule : testbench
